// [tb/adcrf_conv_model.sv]
// Converter stand-in: answers each start with one result after a delay
`default_nettype none

module adcrf_conv_model #(
  parameter int DLY = 1
) (
  input  wire logic   mclk_in,
  input  wire logic   reset_n_in,
  input  wire logic   conv_start_in,
  output logic        conv_done_out,
  output logic [11:0] conv_value_out,
  output logic        conv_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  wait_q;
  logic [11:0] val_q;

  // ==========================================================
  // Results count up from a known seed; error follows bit 0
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wait_q         <= 4'h0;
      val_q          <= 12'hf31;
      conv_done_out  <= 1'b0;
      conv_value_out <= 12'h000;
      conv_err_out   <= 1'b0;
    end else begin
      conv_done_out <= (wait_q == 4'h1);
      if (conv_start_in) wait_q <= 4'(DLY);
      else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        conv_value_out <= val_q;
        conv_err_out   <= val_q[0];
        val_q          <= val_q + 12'h001;
      end else begin
        // Lines are meaningless outside the pulse, so keep them moving
        conv_value_out <= ~conv_value_out;
        conv_err_out   <= ~conv_err_out;
      end
    end
  end
endmodule : adcrf_conv_model

`default_nettype wire

// [tb/adcrf_sva.sv]
// Assertion checker for the ADC result FIFO and pacing block
`default_nettype none

module adcrf_sva #(
  parameter int FIFO_DEPTH = adcrf_pkg::FIFO_DEPTH_DEF
) (
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out,
  input wire logic        repeat_convert_in,
  input wire logic        conv_done_in,
  input wire logic        conv_start_out,
  input wire logic        dma_request_line_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  // ==========================================================
  // Shadow of written config, so outputs can be judged from ports
  logic       taken, rd_go, wp, allow_q, mask_q, force_q, busy_q;
  logic [7:0] wa;
  assign taken = hsel_in & hready_in &
                 (htrans_in == adcrf_pkg::HTRANS_NONSEQ);
  assign rd_go = taken & ~hwrite_in;

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wp      <= 1'b0;
      wa      <= 8'h00;
      allow_q <= 1'b0;
      mask_q  <= 1'b0;
      force_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      wp <= taken & hwrite_in;
      if (taken) wa <= haddr_in[7:0];
      if (wp && wa == adcrf_pkg::ADDR_FIFO_CTRL)
        allow_q <= hwdata_in[adcrf_pkg::DMA_ALLOW_BIT];
      if (wp && wa == adcrf_pkg::ADDR_IRQ_MASK) mask_q <= hwdata_in[0];
      if (wp && wa == adcrf_pkg::ADDR_IRQ_FORCE) force_q <= hwdata_in[0];
      if (conv_start_out) busy_q <= 1'b1;
      else if (conv_done_in) busy_q <= 1'b0;
    end
  end

  // ==========================================================
  // Bus, converter and system-side relations
  resp_okay_a: assert property (hresp_out == adcrf_pkg::HRESP_OKAY)
    else $error("response not OKAY");
  read_wait_a: assert property (rd_go |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read data phase not two cycles");
  write_nowait_a: assert property (taken && hwrite_in |=> hreadyout_out)
    else $error("write data phase stalled");
  result_upper_a: assert property (rd_go &&
    haddr_in[7:0] == adcrf_pkg::ADDR_LATEST_SAMPLE |=> ##1
    hrdata_out[31:12] == 20'h0_0000) else $error("result upper bits set");
  entry_fields_a: assert property (rd_go &&
    haddr_in[7:0] == adcrf_pkg::ADDR_FIFO_DATA |=> ##1
    hrdata_out[31:16] == 16'h0000 && hrdata_out[14:12] == 3'h0)
    else $error("entry reserved bits set");
  dma_gate_a: assert property (!allow_q |-> !dma_request_line_out)
    else $error("dma request while disallowed");
  irq_force_a: assert property (force_q |-> irq_out)
    else $error("forced interrupt absent");
  irq_quiet_a: assert property (!mask_q && !force_q |-> !irq_out)
    else $error("interrupt while masked");
  start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
    else $error("start longer than one cycle");
  one_conv_a: assert property (conv_start_out |-> !busy_q)
    else $error("start while converting");
  start_cause_a: assert property (
    conv_start_out |-> $past(repeat_convert_in))
    else $error("start without repeat mode");
endmodule : adcrf_sva

bind adcrf_top adcrf_sva #(.FIFO_DEPTH(FIFO_DEPTH)) i_sva (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .hrdata_out(hrdata_out), .repeat_convert_in(repeat_convert_in),
  .conv_done_in(conv_done_in), .conv_start_out(conv_start_out),
  .dma_request_line_out(dma_request_line_out), .irq_out(irq_out));

`default_nettype wire

// [tb/adcrf_top_bench.sv]
// Self-checking bench for the ADC result FIFO and pacing block
`default_nettype none

module adcrf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 1;
  logic        mclk_in, reset_n_in, hsel, hwrite, rpt, hrdy;
  logic        done, err, start, dma, irq;
  logic [1:0]  htrans;
  logic [11:0] value;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          fail_count, cmp_count;

  adcrf_top i_dut (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(),
    .hrdata_out(hrdata), .repeat_convert_in(rpt), .conv_done_in(done),
    .conv_value_in(value), .conv_err_in(err), .conv_start_out(start),
    .dma_request_line_out(dma), .irq_out(irq));

  adcrf_conv_model #(.DLY(DLY)) i_conv (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .conv_start_in(start),
    .conv_done_out(done), .conv_value_out(value), .conv_err_out(err));

  // ==========================================================
  // Common tasks
  task end_sim;
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task chkb(input logic s, input logic e);
    chk({31'h0, s}, {31'h0, e});
  endtask : chkb

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= adcrf_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= {24'h00_0000, a};
    do @(posedge mclk_in); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_in); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, adcrf_pkg::WORD_ZERO);
    chk(rd, e);
  endtask : rdc

  // Repeat mode drops at the edge of the last done so no start follows
  task run_conv(input int n);
    int k;
    k = 0;
    rpt <= 1'b1;
    while (k < n) begin
      @(posedge mclk_in);
      if (done === 1'b1) k++;
    end
    rpt <= 1'b0;
  endtask : run_conv

  // Skips m starts, then counts cycles across the next n start gaps
  task span(input int m, input int n, output int c);
    int k;
    k = 0;
    c = 0;
    while (k < m) begin
      @(posedge mclk_in);
      if (start === 1'b1) k++;
    end
    k = 0;
    while (k < n) begin
      @(posedge mclk_in);
      c++;
      if (start === 1'b1) k++;
    end
  endtask : span

  // ==========================================================
  // Scenarios
  task t_reset;
    logic [39:0] tbl [8];
    tbl = '{40'h08_0000_0100, 40'h04_0000_0000, 40'h10_0000_0000,
            40'h14_0000_0001, 40'h18_0000_0000, 40'h1c_0000_0000,
            40'h20_0000_0000, 40'h24_0000_0000};
    chkb(irq, 1'b0);
    chkb(dma, 1'b0);
    wr(8'h04, 32'h0000_0fff);
    wr(8'h24, 32'hffff_ffff);
    foreach (tbl[i]) rdc(tbl[i][39:32], tbl[i][31:0]);
  endtask : t_reset

  task t_fifo;
    logic [31:0] ex [4];
    ex = '{32'h0000_8f31, 32'h0000_0f32, 32'h0000_8f33, 32'h0000_0f34};
    wr(8'h18, 32'h0000_0001);
    wr(8'h08, 32'h0300_000d);
    run_conv(5);
    @(posedge mclk_in);
    chkb(dma, 1'b1);
    chkb(irq, 1'b1);
    rdc(8'h08, 32'h0304_0a0d);
    rdc(8'h04, 32'h0000_0f35);
    rdc(8'h14, 32'h0000_0001);
    rdc(8'h20, 32'h0000_0001);
    foreach (ex[i]) begin
      rdc(8'h0c, ex[i]);
      chkb(dma, i == 0);
    end
    rdc(8'h0c, 32'h0000_0000);
    rdc(8'h08, 32'h0300_0d0d);
    wr(8'h08, 32'h0300_0c0d);
    rdc(8'h08, 32'h0300_010d);
    rdc(8'h14, 32'h0000_0000);
    chkb(irq, 1'b0);
    wr(8'h1c, 32'h0000_0001);
    @(posedge mclk_in);
    chkb(irq, 1'b1);
    rdc(8'h20, 32'h0000_0001);
    wr(8'h1c, 32'h0000_0000);
  endtask : t_fifo

  task t_pack;
    wr(8'h08, 32'h0000_0002);
    run_conv(1);
    rdc(8'h08, 32'h0000_0102);
    rdc(8'h04, 32'h0000_0f36);
    wr(8'h08, 32'h0000_0007);
    run_conv(1);
    @(posedge mclk_in);
    chkb(dma, 1'b0);
    rdc(8'h0c, 32'h0000_80f3);
  endtask : t_pack

  task t_pace;
    int s;
    wr(8'h10, 32'h0000_0580);
    rpt <= 1'b1;
    span(2, 8, s);
    chk(s, 52);
    // Rewrite mid-interval: restarted divider ticks at once
    wr(8'h10, 32'h0000_0580);
    span(0, 1, s);
    chk(s, 3);
    wr(8'h10, 32'h0000_0000);
    span(2, 4, s);
    chk(s, 4 * (DLY + 3));
    rpt <= 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask : t_pace

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  initial begin
    repeat (5000) @(posedge mclk_in);
    fail_count++;
    end_sim;
  end

  initial begin
    reset_n_in = 1'b0;
    hsel       = 1'b0;
    hwrite     = 1'b0;
    htrans     = 2'h0;
    haddr      = 32'h0000_0000;
    hwdata     = 32'h0000_0000;
    rpt        = 1'b0;
    fail_count = 0;
    cmp_count  = 0;
    repeat (4) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    @(posedge mclk_in);
    t_reset;
    t_fifo;
    t_pack;
    t_pace;
    end_sim;
  end
endmodule : adcrf_top_bench

`default_nettype wire

// [verilog/adcrf_pkg.sv]
// Package for the ADC result FIFO and pacing block: map, fields, types
`default_nettype none

package adcrf_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADDR_LATEST_SAMPLE = 8'h04;
  localparam logic [7:0] ADDR_FIFO_CTRL     = 8'h08;
  localparam logic [7:0] ADDR_FIFO_DATA     = 8'h0c;
  localparam logic [7:0] ADDR_PACE_PERIOD   = 8'h10;
  localparam logic [7:0] ADDR_RAW_IRQ       = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h18;
  localparam logic [7:0] ADDR_IRQ_FORCE     = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h20;

  // ==========================================================
  // Field positions
  localparam int SAMPLE_W      = 12;
  localparam int LEVEL_W       = 4;
  localparam int TRIG_LSB      = 24;
  localparam int LEVEL_LSB     = 16;
  localparam int LOST_BIT      = 11;
  localparam int STARVED_BIT   = 10;
  localparam int NO_SPACE_BIT  = 9;
  localparam int HAS_NONE_BIT  = 8;
  localparam int DMA_ALLOW_BIT = 3;
  localparam int ERR_TAG_BIT   = 2;
  localparam int PACK_BIT      = 1;
  localparam int FIFO_EN_BIT   = 0;
  localparam int ENTRY_ERR_BIT = 15;
  localparam int PACE_INT_LSB  = 8;
  localparam int PACE_INT_W    = 16;
  localparam int PACE_DIVISOR_SUB_PART_LSB = 0;
  localparam int PACE_DIVISOR_SUB_PART_W   = 8;
  localparam int IRQ_FIFO_BIT  = 0;
  localparam int PACK_SHIFT    = 4;

  localparam int FIFO_DEPTH_DEF = 4;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic                err;
    logic [SAMPLE_W-1:0] value;
  } adcrf_entry_type;

  typedef struct packed {
    logic [LEVEL_W-1:0] trigger_level;
    logic               dma_allow;
    logic               err_tag;
    logic               byte_pack;
    logic               fifo_en;
  } adcrf_cfg_type;

endpackage : adcrf_pkg

`default_nettype wire

// [verilog/adcrf_top.sv]
// ADC result register, result FIFO, DMA request, pacing and FIFO interrupt
//
// Summary of operation
// R1 - latest_sample holds last 12-bit result, read-only, upper bits zero
// R2 - DMA request and FIFO interrupt high when fill count >= trigger level
// R3 - Four-bit read-only fill count shows entries waiting in FIFO
// R4 - Result arriving while FIFO full sets sticky lost flag, write-one clear
// R5 - FIFO read while empty sets sticky starved flag, write-one clear
// R6 - Read-only no-space and has-none flags for full and empty FIFO
// R7 - DMA request line only raised while dma_request_allow set
// R8 - Error-tag option stores each conversion error beside its result
// R9 - Byte packing keeps only the eight most significant result bits
// R10 - FIFO enable pushes one entry per completed conversion, else nothing
// R11 - FIFO word: value in bits 11:0, error tag fixed at bit 15
// R12 - Reading FIFO data returns oldest entry and removes it
// R13 - Non-zero pace period paces repeated conversions at fixed intervals
// R14 - Writing the pace divisor restarts the pacing count
// R15 - Interval is one plus whole divisor plus fraction over 256 cycles
// R16 - Fraction realised by first-order delta-sigma dithering of intervals
// R17 - Raw FIFO interrupt bit 0 high while level reaches trigger level
// R18 - Status equals raw AND enable OR force, drives interrupt output
// R19 - Repeat mode starts next conversion right after previous completes
// R20 - Error input means the conversion result is undefined or noisy
`default_nettype none

module adcrf_top #(
  parameter int FIFO_DEPTH = adcrf_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  // Converter side
  input  wire logic        repeat_convert_in,
  input  wire logic        conv_done_in,
  input  wire logic [11:0] conv_value_in,
  input  wire logic        conv_err_in,
  output logic             conv_start_out,
  // System side
  output logic             dma_request_line_out,
  output logic             irq_out
);

  timeunit 1ns;
  timeprecision 1ps;
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int LW    = adcrf_pkg::LEVEL_W;
  localparam int SW    = adcrf_pkg::SAMPLE_W;
  localparam int IW    = adcrf_pkg::PACE_INT_W;
  localparam int FW    = adcrf_pkg::PACE_DIVISOR_SUB_PART_W;
  localparam logic [LW-1:0] DEPTH_L = LW'(FIFO_DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(FIFO_DEPTH - 1);

  // ==========================================================
  // Bus phase tracking
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } adcrf_bus_type;

  adcrf_bus_type         bus_reg;
  logic                  wr_pend_reg;
  logic [7:0]            addr_reg;
  logic [31:0]           hrdata_reg;
  logic                  addr_ok;
  logic                  rd_fire;
  logic                  wr_fire;
  logic                  pop_req;

  // ==========================================================
  // Control and status state
  adcrf_pkg::adcrf_cfg_type    cfg_reg;
  logic [SW-1:0]               latest_reg;
  logic                        lost_reg;
  logic                        starved_reg;
  logic [IW-1:0]               pace_int_reg;
  logic [FW-1:0]               pace_divisor_sub_part_reg;
  logic                        irq_mask_reg;
  logic                        irq_force_reg;

  adcrf_pkg::adcrf_entry_type  mem_reg [FIFO_DEPTH];
  adcrf_pkg::adcrf_entry_type  push_entry;
  logic [PTR_W-1:0]            wr_ptr_reg;
  logic [PTR_W-1:0]            rd_ptr_reg;
  logic [LW-1:0]               level_reg;
  logic                        fifo_full;
  logic                        fifo_empty;
  logic                        do_push;
  logic                        do_pop;
  logic                        raw_irq;
  logic                        irq_status;

  logic                        busy_reg;
  logic                        start_reg;
  logic [IW-1:0]               pace_cnt_reg;
  logic [FW-1:0]               divisor_sub_part_acc_reg;
  logic                        extra_reg;
  logic                        tick_pend_reg;
  logic                        pace_tick;
  logic                        pace_on;
  logic [FW:0]                 divisor_sub_part_sum;
  logic                        pace_wr;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == adcrf_pkg::ADDR_LATEST_SAMPLE)
               | (a == adcrf_pkg::ADDR_FIFO_CTRL)
               | (a == adcrf_pkg::ADDR_FIFO_DATA)
               | (a == adcrf_pkg::ADDR_PACE_PERIOD)
               | (a == adcrf_pkg::ADDR_RAW_IRQ)
               | (a == adcrf_pkg::ADDR_IRQ_MASK)
               | (a == adcrf_pkg::ADDR_IRQ_FORCE)
               | (a == adcrf_pkg::ADDR_IRQ_STATUS);
  endfunction : known_addr

  // ==========================================================
  // Bus slave
  // Reads take one wait state so a write just ahead is always visible
  assign addr_ok = hsel_in && hready_in
                 && (htrans_in == adcrf_pkg::HTRANS_NONSEQ);
  assign rd_fire = addr_ok && !hwrite_in;
  assign wr_fire = addr_ok && hwrite_in;
  assign hreadyout_out = (bus_reg == BUS_IDLE);
  assign hresp_out     = adcrf_pkg::HRESP_OKAY;
  assign hrdata_out    = hrdata_reg;
  assign pop_req = (bus_reg == BUS_READ)
                 && (addr_reg == adcrf_pkg::ADDR_FIFO_DATA);
  assign pace_wr = wr_pend_reg
                 && (addr_reg == adcrf_pkg::ADDR_PACE_PERIOD);

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      bus_reg     <= BUS_IDLE;
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= wr_fire;
      if (addr_ok) begin
        addr_reg <= known_addr(haddr_in[7:0]) && (haddr_in[31:8] == '0)
                  ? haddr_in[7:0] : 8'h00;
      end
      unique case (bus_reg)
        BUS_IDLE: begin
          if (rd_fire) begin
            bus_reg <= BUS_READ;
          end
        end
        BUS_READ: begin
          bus_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      hrdata_reg <= adcrf_pkg::WORD_ZERO;
    end else if (bus_reg == BUS_READ) begin
      hrdata_reg <= adcrf_pkg::WORD_ZERO;
      unique case (addr_reg)
        adcrf_pkg::ADDR_LATEST_SAMPLE:
          hrdata_reg[SW-1:0] <= latest_reg;                 // see R1
        adcrf_pkg::ADDR_FIFO_CTRL: begin
          hrdata_reg[adcrf_pkg::TRIG_LSB +: LW] <= cfg_reg.trigger_level;
          hrdata_reg[adcrf_pkg::LEVEL_LSB +: LW] <= level_reg; // see R3
          hrdata_reg[adcrf_pkg::LOST_BIT]      <= lost_reg;
          hrdata_reg[adcrf_pkg::STARVED_BIT]   <= starved_reg;
          hrdata_reg[adcrf_pkg::NO_SPACE_BIT]  <= fifo_full;  // see R6
          hrdata_reg[adcrf_pkg::HAS_NONE_BIT]  <= fifo_empty; // see R6
          hrdata_reg[adcrf_pkg::DMA_ALLOW_BIT] <= cfg_reg.dma_allow;
          hrdata_reg[adcrf_pkg::ERR_TAG_BIT]   <= cfg_reg.err_tag;
          hrdata_reg[adcrf_pkg::PACK_BIT]      <= cfg_reg.byte_pack;
          hrdata_reg[adcrf_pkg::FIFO_EN_BIT]   <= cfg_reg.fifo_en;
        end
        adcrf_pkg::ADDR_FIFO_DATA: begin
          // Empty read returns zero; the starved flag records it
          if (!fifo_empty) begin                              // see R12
            hrdata_reg[adcrf_pkg::ENTRY_ERR_BIT] <= mem_reg[rd_ptr_reg].err;
            hrdata_reg[SW-1:0] <= mem_reg[rd_ptr_reg].value;  // see R11
          end
        end
        adcrf_pkg::ADDR_PACE_PERIOD: begin
          hrdata_reg[adcrf_pkg::PACE_INT_LSB +: IW]  <= pace_int_reg;
          hrdata_reg[adcrf_pkg::PACE_DIVISOR_SUB_PART_LSB +: FW] <= pace_divisor_sub_part_reg;
        end
        adcrf_pkg::ADDR_RAW_IRQ:
          hrdata_reg[adcrf_pkg::IRQ_FIFO_BIT] <= raw_irq;     // see R17
        adcrf_pkg::ADDR_IRQ_MASK:
          hrdata_reg[adcrf_pkg::IRQ_FIFO_BIT] <= irq_mask_reg;
        adcrf_pkg::ADDR_IRQ_FORCE:
          hrdata_reg[adcrf_pkg::IRQ_FIFO_BIT] <= irq_force_reg;
        adcrf_pkg::ADDR_IRQ_STATUS:
          hrdata_reg[adcrf_pkg::IRQ_FIFO_BIT] <= irq_status;  // see R18
        default:
          hrdata_reg <= adcrf_pkg::WORD_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Software-written control
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cfg_reg       <= '0;
      pace_int_reg  <= '0;
      pace_divisor_sub_part_reg <= '0;
      irq_mask_reg  <= 1'b0;
      irq_force_reg <= 1'b0;
    end else if (wr_pend_reg) begin
      unique case (addr_reg)
        adcrf_pkg::ADDR_FIFO_CTRL: begin
          cfg_reg.trigger_level <= hwdata_in[adcrf_pkg::TRIG_LSB +: LW];
          cfg_reg.dma_allow <= hwdata_in[adcrf_pkg::DMA_ALLOW_BIT];
          cfg_reg.err_tag   <= hwdata_in[adcrf_pkg::ERR_TAG_BIT];
          cfg_reg.byte_pack <= hwdata_in[adcrf_pkg::PACK_BIT];
          cfg_reg.fifo_en   <= hwdata_in[adcrf_pkg::FIFO_EN_BIT];
        end
        adcrf_pkg::ADDR_PACE_PERIOD: begin
          pace_int_reg  <= hwdata_in[adcrf_pkg::PACE_INT_LSB +: IW];
          pace_divisor_sub_part_reg <= hwdata_in[adcrf_pkg::PACE_DIVISOR_SUB_PART_LSB +: FW];
        end
        adcrf_pkg::ADDR_IRQ_MASK:
          irq_mask_reg <= hwdata_in[adcrf_pkg::IRQ_FIFO_BIT];
        adcrf_pkg::ADDR_IRQ_FORCE:
          irq_force_reg <= hwdata_in[adcrf_pkg::IRQ_FIFO_BIT];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Latest result and FIFO
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      latest_reg <= '0;
    end else if (conv_done_in) begin
      latest_reg <= conv_value_in;                            // see R1
    end
  end

  always_comb begin
    push_entry.err   = cfg_reg.err_tag & conv_err_in;         // see R8, R20
    push_entry.value = cfg_reg.byte_pack                      // see R9
                     ? (conv_value_in >> adcrf_pkg::PACK_SHIFT)
                     : conv_value_in;
  end

  assign fifo_full  = (level_reg == DEPTH_L);
  assign fifo_empty = (level_reg == '0);
  assign do_push = conv_done_in && cfg_reg.fifo_en && !fifo_full; // see R10
  assign do_pop  = pop_req && !fifo_empty;                        // see R12

  always_ff @(posedge mclk_in) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= push_entry;                      // see R11
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      end
      if (do_pop) begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (do_push && !do_pop) begin
        level_reg <= level_reg + LW'(1);                      // see R3
      end else if (do_pop && !do_push) begin
        level_reg <= level_reg - LW'(1);                      // see R12
      end
    end
  end

  // Sticky error flags: a new event in the clearing cycle wins
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      lost_reg    <= 1'b0;
      starved_reg <= 1'b0;
    end else begin
      if (conv_done_in && cfg_reg.fifo_en && fifo_full) begin
        lost_reg <= 1'b1;                                     // see R4
      end else if (wr_pend_reg && addr_reg == adcrf_pkg::ADDR_FIFO_CTRL
                   && hwdata_in[adcrf_pkg::LOST_BIT]) begin
        lost_reg <= 1'b0;                                     // see R4
      end
      if (pop_req && fifo_empty) begin
        starved_reg <= 1'b1;                                  // see R5
      end else if (wr_pend_reg && addr_reg == adcrf_pkg::ADDR_FIFO_CTRL
                   && hwdata_in[adcrf_pkg::STARVED_BIT]) begin
        starved_reg <= 1'b0;                                  // see R5
      end
    end
  end

  // ==========================================================
  // Request and interrupt
  assign raw_irq    = (level_reg >= cfg_reg.trigger_level);   // see R2, R17
  assign irq_status = (raw_irq & irq_mask_reg) | irq_force_reg; // see R18
  assign irq_out    = irq_status;                             // see R18
  assign dma_request_line_out = cfg_reg.dma_allow & raw_irq;  // see R2, R7

  // ==========================================================
  // Pacing divider
  // Each interval lasts int+1 cycles, plus one when the fraction carries
  assign pace_on  = (pace_int_reg != '0) || (pace_divisor_sub_part_reg != '0);
  assign divisor_sub_part_sum = {1'b0, divisor_sub_part_acc_reg} + {1'b0, pace_divisor_sub_part_reg}; // see R16
  assign pace_tick = (pace_cnt_reg == '0) && !extra_reg && !pace_wr;

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      pace_cnt_reg <= '0;
      divisor_sub_part_acc_reg <= '0;
      extra_reg    <= 1'b0;
    end else if (pace_wr || !repeat_convert_in) begin
      pace_cnt_reg <= '0;                                     // see R14
      divisor_sub_part_acc_reg <= '0;                                     // see R14
      extra_reg    <= 1'b0;
    end else if (extra_reg) begin
      extra_reg <= 1'b0;                                      // see R16
    end else if (pace_cnt_reg != '0) begin
      pace_cnt_reg <= pace_cnt_reg - IW'(1);                  // see R15
    end else begin
      pace_cnt_reg <= pace_int_reg;                           // see R15
      divisor_sub_part_acc_reg <= divisor_sub_part_sum[FW-1:0];                       // see R16
      extra_reg    <= divisor_sub_part_sum[FW];                           // see R16
    end
  end

  // ==========================================================
  // Conversion sequencing
  // A tick while converting is held in one pending bit, so ticks beyond one per conversion are dropped
  assign conv_start_out = start_reg;

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      tick_pend_reg <= 1'b0;
    end else if (!repeat_convert_in || !pace_on) begin
      tick_pend_reg <= 1'b0;
    end else if (pace_tick) begin
      tick_pend_reg <= 1'b1;                                  // see R13
    end else if (start_reg) begin
      tick_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      busy_reg  <= 1'b0;
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      if (start_reg) begin
        busy_reg <= 1'b1;
      end else if (conv_done_in) begin
        busy_reg <= 1'b0;
      end else if (repeat_convert_in && !busy_reg) begin
        if (!pace_on) begin
          start_reg <= 1'b1;                                  // see R19
        end else if (tick_pend_reg) begin
          start_reg <= 1'b1;                                  // see R13
        end
      end
    end
  end

endmodule : adcrf_top

`default_nettype wire
